/* File: design/bpl_pkg.sv */
// Shared constants and carrier types for the backplane serial TDM link
package bpl_pkg;

  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam int WORD_BITS       = 32;  // Bits per channel slot
  localparam int SLOTS           = 4;   // Channel slots per data line
  localparam int FRAME_BITS      = WORD_BITS * SLOTS;
  localparam int LINES_PER_GROUP = 6;   // Data lines per board group
  localparam int GROUPS          = 2;   // First and second board group
  localparam int LINES           = LINES_PER_GROUP * GROUPS;
  localparam int LINES_PER_BOARD = 4;   // Lines serving a 16 channel board
  localparam logic [6:0] FRAME_LAST = 7'h7f;  // Last bit of a frame

  // ----------------------------------------
  // Rates and timing
  // ----------------------------------------
  localparam int BIT_RATE_HZ     = 2 ** 26;  // One bit per link clock
  localparam int SAMPLE_RATE_HZ  = BIT_RATE_HZ / FRAME_BITS;
  localparam int SYS_CLK_HZ      = 200_000_000;
  localparam int SYS_PERIOD_NS   = 5;
  localparam int SYNC_PERIOD_S   = 1;        // Second sync pulse period
  localparam int SYNC_PERIOD_CYC = SYS_CLK_HZ * SYNC_PERIOD_S;
  localparam int SYNC_WIDTH_NS   = 100;      // Width of driven sync pulse
  localparam int SYNC_WIDTH_CYC  = SYNC_WIDTH_NS / SYS_PERIOD_NS;
  localparam int PEER_TIMEOUT_S  = 2;        // Missing pulses drop peer
  localparam int PEER_TIMEOUT_CYC = SYS_CLK_HZ * PEER_TIMEOUT_S;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Four channel words of one line, word[0] is the first slot
  typedef struct packed {
    logic [SLOTS-1:0][WORD_BITS-1:0] word;
  } bpl_line_frame_t;

  // Strap levels steering line direction and routing
  typedef struct packed {
    logic [GROUPS-1:0] adc;     // Group serves an ADC board
    logic              mirror;  // Mirror local upstream to backplane
  } bpl_strap_t;

endpackage

/* File: design/bpl_link_top.sv */
// Uplink side serial TDM link: sync pulse, peer detect, line serdes
//
// Function
// - Each line runs one bit per link clock
// - Each line carries four channel slots
// - Each slot is one 32-bit word
// - Four lines serve a sixteen channel board
// - Upstream line receives for ADC, drives DAC
// - Downstream line drives for ADC, receives DAC
// - Three clocks, twelve data lines per direction
// - Lines 1-6 first board, 7-12 second
// - Second downstream clock carries sync pulse (here both dn_clk_o lines carry the main clock, sync goes out on dn_sync_o)
// - Main clock forwarded, also times downstream data
// - Sync on upstream clock two means uplink peer
// - Uplink serves two local, two remote engines
// - Local side: upstream, clocks, status lines only
// - Local upstream data mirrored onto backplane downstream
// - Uplink peer reads downstream lines as upstream
// - Converter side: seven clocks, twenty-one data lines
// - Converter link is twenty-eight differential pairs
`timescale 1ns/100ps
`default_nettype none

module bpl_link_top #(
  parameter int SYNC_PERIOD  = bpl_pkg::SYNC_PERIOD_CYC,   // Sync pulse period
  parameter int PEER_TIMEOUT = bpl_pkg::PEER_TIMEOUT_CYC   // Peer loss timeout
) (
  // System clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // Forwarded main clock, the link domain
  input  wire logic                   link_clk_i,
  // Board straps, asynchronous levels
  input  wire bpl_pkg::bpl_strap_t    strap_i,
  // Backplane clock lines
  output wire logic [1:0]             dn_clk_o,
  output logic                        dn_sync_o,
  input  wire logic                   up_sync_i,
  // Backplane upstream data lines
  input  wire logic [bpl_pkg::LINES-1:0] up_data_i,
  output logic [bpl_pkg::LINES-1:0]   up_data_o,
  output logic [bpl_pkg::LINES-1:0]   up_data_oe_n_o,
  // Backplane downstream data lines
  input  wire logic [bpl_pkg::LINES-1:0] dn_data_i,
  output logic [bpl_pkg::LINES-1:0]   dn_data_o,
  output logic [bpl_pkg::LINES-1:0]   dn_data_oe_n_o,
  // Local filter engine lines
  input  wire logic [bpl_pkg::LINES-1:0] loc_up_i,
  output logic [bpl_pkg::LINES-1:0]   loc_status_o,
  // User side, link domain
  input  wire bpl_pkg::bpl_line_frame_t [bpl_pkg::LINES-1:0] tx_frame_i,
  output logic                        tx_take_o,
  output bpl_pkg::bpl_line_frame_t [bpl_pkg::LINES-1:0] rx_frame_o,
  output logic                        rx_valid_o,
  // Status, system domain
  output logic                        peer_uplink_o
);

  // ----------------------------------------
  // System domain: second sync pulse
  // ----------------------------------------
  logic [31:0] sync_cnt_reg;   // Position within the sync period
  logic        sync_pulse_reg; // Driven pulse level

  // Period counter, free running after reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_cnt_reg <= '0;
    end else if (sync_cnt_reg == 32'(SYNC_PERIOD - 1)) begin
      sync_cnt_reg <= '0;
    end else begin
      sync_cnt_reg <= sync_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_pulse_reg <= 1'b0;
    end else begin
      sync_pulse_reg <= (sync_cnt_reg < 32'(bpl_pkg::SYNC_WIDTH_CYC));
    end
  end

  assign dn_sync_o = sync_pulse_reg;

  // main clock forwarded
  // Both groups see the same clock that times the data lines
  assign dn_clk_o = {2{link_clk_i}};

  // ----------------------------------------
  // System domain: uplink peer detection
  // ----------------------------------------
  logic        up_sync_s1_reg;  // First synchroniser stage
  logic        up_sync_s2_reg;  // Second synchroniser stage
  logic        up_sync_d_reg;   // Previous level for edge detect
  logic [31:0] peer_age_reg;    // Cycles since last pulse
  logic        peer_reg;        // Far end is an uplink
  logic        sync_edge;       // Rising edge seen

  // Pin passes two flops before use
  always_ff @(posedge sys_clk_i) begin
    up_sync_s1_reg <= up_sync_i;
    up_sync_s2_reg <= up_sync_s1_reg;
  end

  // Edge history
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      up_sync_d_reg <= 1'b0;
    end else begin
      up_sync_d_reg <= up_sync_s2_reg;
    end
  end

  assign sync_edge = up_sync_s2_reg & ~up_sync_d_reg;

  // pulse marks uplink peer
  // A timeout drops the peer so an unplugged uplink is noticed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      peer_reg     <= 1'b0;
      peer_age_reg <= '0;
    end else if (sync_edge) begin
      peer_reg     <= 1'b1;
      peer_age_reg <= '0;
    end else if (peer_age_reg == 32'(PEER_TIMEOUT - 1)) begin
      peer_reg     <= 1'b0;
    end else begin
      peer_age_reg <= peer_age_reg + 32'h1;
    end
  end

  assign peer_uplink_o = peer_reg;

  // ----------------------------------------
  // Link domain: reset and level crossings
  // ----------------------------------------
  logic [1:0]          lrst_sync_reg;  // Reset into link domain
  logic                lrst;           // Link domain reset
  bpl_pkg::bpl_strap_t strap_s1_reg;   // Strap first stage
  bpl_pkg::bpl_strap_t strap_s2_reg;   // Strap second stage
  logic                peer_s1_reg;    // Peer level first stage
  logic                peer_s2_reg;    // Peer level second stage

  // Two flop crossing for each level
  always_ff @(posedge link_clk_i) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst_i};
    strap_s1_reg  <= strap_i;
    strap_s2_reg  <= strap_s1_reg;
    peer_s1_reg   <= peer_reg;
    peer_s2_reg   <= peer_s1_reg;
  end

  assign lrst = lrst_sync_reg[1];

  // ----------------------------------------
  // Link domain: frame counter
  // ----------------------------------------
  logic [6:0] bit_cnt_reg;  // Bit within frame, slot in top two bits
  logic       frame_end;    // Last bit of a frame

  assign frame_end = (bit_cnt_reg == bpl_pkg::FRAME_LAST);

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      bit_cnt_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 7'h1;
    end
  end

  assign tx_take_o = frame_end & ~lrst;

  // ----------------------------------------
  // Link domain: per line serdes
  // ----------------------------------------
  logic [bpl_pkg::LINES-1:0] tx_bit;    // Serialised user bit per line
  logic [bpl_pkg::LINES-1:0] rx_bit;    // Selected receive bit per line
  logic [bpl_pkg::LINES-1:0] line_adc;  // Line serves an ADC board
  logic [bpl_pkg::FRAME_BITS-1:0] rx_sh [bpl_pkg::LINES];  // Receive shifters

  genvar l;
  generate
    for (l = 0; l < bpl_pkg::LINES; l++) begin : g_line
      logic [bpl_pkg::FRAME_BITS-1:0] tx_sh_reg;  // Transmit shifter
      logic                           tx_bit_reg; // Bit on the wire
      logic                           mir_reg;    // Mirrored local bit

      assign line_adc[l] = strap_s2_reg.adc[l / bpl_pkg::LINES_PER_GROUP];

      always_ff @(posedge link_clk_i) begin
        if (lrst) begin
          tx_sh_reg  <= '0;
          tx_bit_reg <= 1'b0;
        end else if (frame_end) begin
          tx_sh_reg  <= {tx_frame_i[l].word[0], tx_frame_i[l].word[1],
                         tx_frame_i[l].word[2], tx_frame_i[l].word[3]};
          tx_bit_reg <= tx_frame_i[l].word[0][bpl_pkg::WORD_BITS-1];
        end else begin
          tx_sh_reg  <= {tx_sh_reg[bpl_pkg::FRAME_BITS-2:0], 1'b0};
          tx_bit_reg <= tx_sh_reg[bpl_pkg::FRAME_BITS-2];
        end
      end

      assign tx_bit[l] = tx_bit_reg;

      always_ff @(posedge link_clk_i) begin
        if (lrst) begin
          mir_reg <= 1'b0;
        end else begin
          mir_reg <= loc_up_i[l];
        end
      end

      // peer swaps direction
      // An uplink peer drives our downstream pins with its upstream data
      assign rx_bit[l] = (line_adc[l] ^ peer_s2_reg) ? up_data_i[l]
                                                     : dn_data_i[l];

      always_ff @(posedge link_clk_i) begin
        if (lrst) begin
          rx_sh[l] <= '0;
        end else begin
          rx_sh[l] <= {rx_sh[l][bpl_pkg::FRAME_BITS-2:0], rx_bit[l]};
        end
      end

      assign up_data_oe_n_o[l] = line_adc[l];
      assign up_data_o[l]      = tx_bit[l];

      assign dn_data_oe_n_o[l] = ~line_adc[l];
      assign dn_data_o[l]      = strap_s2_reg.mirror ? mir_reg : tx_bit[l];

      assign loc_status_o[l] = tx_bit[l];
    end
  endgenerate

  // ----------------------------------------
  // Link domain: receive frame capture
  // ----------------------------------------
  // Frame output, words held until next frame completes
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      rx_frame_o <= '0;
    end else if (frame_end) begin
      // first slot received lands in word zero
      for (int i = 0; i < bpl_pkg::LINES; i++) begin
        for (int w = 0; w < bpl_pkg::SLOTS - 1; w++) begin
          rx_frame_o[i].word[w] <=
            rx_sh[i][bpl_pkg::FRAME_BITS-2-w*bpl_pkg::WORD_BITS -: bpl_pkg::WORD_BITS];
        end
        rx_frame_o[i].word[bpl_pkg::SLOTS-1] <= {rx_sh[i][bpl_pkg::WORD_BITS-2:0], rx_bit[i]};
      end
    end
  end

  // Valid pulse one cycle after the last bit
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= frame_end;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Edge then peer flag in the following cycle
  sequence s_sync_edge;
    !up_sync_d_reg && up_sync_s2_reg;
  endsequence

  chk_frame_wrap: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    frame_end |=> bit_cnt_reg == 7'h00)
    else $error("frame counter did not wrap");

  chk_rx_frame_period: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    rx_valid_o |-> ##128 rx_valid_o)
    else $error("receive frame period is not 128 bits");

  chk_rx_valid_gap: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    rx_valid_o |=> !rx_valid_o [*8])
    else $error("receive valid repeated too soon");

  chk_up_dir_adc: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    strap_s2_reg.adc[0] |-> up_data_oe_n_o[0] && !dn_data_oe_n_o[0])
    else $error("first group ADC direction wrong");

  chk_dn_dir_dac: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    !strap_s2_reg.adc[1] |-> dn_data_oe_n_o[11] && !up_data_oe_n_o[11])
    else $error("second group DAC direction wrong");

  chk_msb_first: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    tx_take_o |=> up_data_o[0] == $past(tx_frame_i[0].word[0][31]))
    else $error("first serial bit is not slot zero MSB");

  chk_slot_order: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    tx_take_o |-> ##33 up_data_o[0] == $past(tx_frame_i[0].word[1][31], 33))
    else $error("second slot not sent after first");

  chk_mirror_path: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    strap_s2_reg.mirror && $stable(strap_s2_reg.mirror)
      |-> dn_data_o[3] == $past(loc_up_i[3]))
    else $error("local upstream not mirrored to backplane");

  chk_sync_width: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(dn_sync_o) |-> dn_sync_o [*8])
    else $error("sync pulse too short");

  chk_peer_detect: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    s_sync_edge |=> peer_uplink_o && peer_age_reg == 32'h0)
    else $error("sync pulse did not mark uplink peer");

endmodule

`default_nettype wire

/* File: bench/bpl_far_end.sv */
// Far end peer model: serial frames on the backplane lines and sync pulses
`timescale 1ns/100ps
`default_nettype none

module bpl_far_end (
  // Link clock and frame alignment
  input  wire logic                     link_clk_i,
  input  wire logic                     take_i,
  // Control from the bench
  input  wire bpl_pkg::bpl_line_frame_t frame_i,
  input  wire logic                     sel_up_i,
  input  wire logic                     sync_run_i,
  // Line and sync outputs
  output logic [11:0]                   up_data_o,
  output logic [11:0]                   dn_data_o,
  output logic                          up_sync_o
);
  logic       take_q = 1'b0;  // Frame start seen last edge
  logic [6:0] idx    = 7'h00; // Bit position in the frame
  logic [4:0] scnt   = 5'h00; // Sync pulse spacing
  logic       bit_v;          // Current serial bit
  logic [11:0] vec;           // Odd lines carry the inverse

  initial begin
    up_data_o = 12'h000;
    dn_data_o = 12'h000;
    up_sync_o = 1'b0;
  end

  // Frame starts one cycle after the take edge, like a loopback
  always @(posedge link_clk_i) begin
    take_q <= take_i;
  end

  // one bit per link clock, timed by it
  always @(negedge link_clk_i) begin
    idx = take_q ? 7'h00 : idx + 7'h01;
    bit_v = frame_i.word[idx[6:5]][5'h1f - idx[4:0]];
    vec = {6{~bit_v, bit_v}};
    // Unused direction shows the inverse, never a stale copy
    up_data_o <= vec ^ {12{~sel_up_i}};
    dn_data_o <= vec ^ {12{sel_up_i}};
  end

  // peer sync: 4 link cycles high every 32
  always @(posedge link_clk_i) begin
    scnt <= scnt + 5'h01;
    up_sync_o <= sync_run_i && (scnt < 5'h04);
  end
endmodule
`default_nettype wire

/* File: bench/tb_bpl_link_top.sv */
// Self-checking bench for the backplane serial TDM link
`timescale 1ns/100ps
`default_nettype none

module tb_bpl_link_top;
  localparam int SP = 200;  // Shortened sync period
  localparam int PT = 500;  // Shortened peer timeout
  logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, dn_sync, up_sync, tx_take;
  logic rx_valid, peer, p_sel = 1'b0, p_run = 1'b0;
  logic [1:0]  dn_clk;
  logic [11:0] up_di, up_do, up_oe_n, dn_di, dn_do, dn_oe_n, loc_st;
  logic [11:0] loc_up = 12'h000;
  bpl_pkg::bpl_strap_t strap = '0;
  bpl_pkg::bpl_line_frame_t [11:0] tx_frame = '0, rx_frame;
  bpl_pkg::bpl_line_frame_t p_frame = '0;
  int mismatches = 0, n_compared = 0;

  bpl_link_top #(.SYNC_PERIOD(SP), .PEER_TIMEOUT(PT)) i_bpl_link_top (
    .sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .strap_i(strap),
    .dn_clk_o(dn_clk), .dn_sync_o(dn_sync), .up_sync_i(up_sync),
    .up_data_i(up_di), .up_data_o(up_do), .up_data_oe_n_o(up_oe_n),
    .dn_data_i(dn_di), .dn_data_o(dn_do), .dn_data_oe_n_o(dn_oe_n),
    .loc_up_i(loc_up), .loc_status_o(loc_st), .tx_frame_i(tx_frame),
    .tx_take_o(tx_take), .rx_frame_o(rx_frame), .rx_valid_o(rx_valid),
    .peer_uplink_o(peer));
  bpl_far_end i_bpl_far_end (.link_clk_i(link_clk), .take_i(tx_take),
    .frame_i(p_frame), .sel_up_i(p_sel), .sync_run_i(p_run),
    .up_data_o(up_di), .dn_data_o(dn_di), .up_sync_o(up_sync));

  // Clocks: 5 ns system, 48 ns link started off phase
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Distinct word per line and slot, asymmetric bits
  function automatic bpl_pkg::bpl_line_frame_t mk(input int l);
    for (int w = 0; w < 4; w++) mk.word[w] = 32'h8c1e_5a30 ^ {16'h0000, 8'(l), 8'(w)};
  endfunction

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait ran out: count it and close the run
  task automatic guard(input int c, input int lim);
    if (c >= lim) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Bounded wait on take (rx=0) or receive pulse (rx=1), sampled mid cycle
  task automatic wait_link(input bit rx);
    for (int i = 0; i < 400; i++) begin
      @(negedge link_clk);
      if ((rx ? rx_valid : tx_take) === 1'b1) return;
    end
    mismatches++;
    wrap_up();
  endtask

  task automatic t_sync();
    int c;
    for (c = 0; c < 250 && dn_sync !== 1'b1; c++) @(negedge sys_clk);
    guard(c, 250);
    for (c = 0; c < 250 && dn_sync === 1'b1; c++) @(negedge sys_clk);
    guard(c, 250);
    chk("sync high", 128'(bpl_pkg::SYNC_WIDTH_CYC), 128'(c));
    for (c = 0; c < 250 && dn_sync === 1'b0; c++) begin
      @(negedge sys_clk);
      // Off any link edge so the forwarded copy has settled
      #1.5;
      chk("clk fwd", {126'h0, {2{link_clk}}}, 128'(dn_clk));
    end
    guard(c, 250);
    chk("sync low", 128'(SP - bpl_pkg::SYNC_WIDTH_CYC), 128'(c));
    $display("done sync");
  endtask

  task automatic t_dir();
    logic [11:0] e;
    for (int a = 0; a < 4; a++) begin
      @(negedge sys_clk);
      strap.adc = 2'(a);
      repeat (6) @(negedge link_clk);
      e = {{6{strap.adc[1]}}, {6{strap.adc[0]}}};
      chk("oe_n", 128'({e, ~e}), 128'({up_oe_n, dn_oe_n}));
    end
    $display("done direction");
  endtask

  task automatic t_tx();
    logic [11:0] e;
    for (int l = 0; l < 12; l++) tx_frame[l] = mk(l);
    wait_link(0);
    for (int k = 0; k < 256; k++) begin
      @(negedge link_clk);
      for (int l = 0; l < 12; l++) e[l] = tx_frame[l].word[(k % 128) / 32][31 - k % 32];
      chk("tx bits", 128'({e, e, e}), 128'({up_do, loc_st, dn_do}));
    end
    $display("done tx");
  endtask

  task automatic t_mirror();
    logic [11:0] prev;
    @(negedge sys_clk);
    strap.mirror = 1'b1;
    repeat (6) @(negedge link_clk);
    for (int k = 0; k < 16; k++) begin
      if (k > 0) chk("mirror", 128'(prev), 128'(dn_do));
      prev = 12'(k * 12'h2d3) ^ 12'ha5c;
      loc_up = prev;
      @(negedge link_clk);
    end
    strap.mirror = 1'b0;
    $display("done mirror");
  endtask

  task automatic t_rx(input logic [1:0] adc, input logic sel);
    strap.adc = adc;
    p_sel = sel;
    p_frame = mk(77);
    // Let the straps cross before the discarded frame ends
    repeat (3) @(negedge link_clk);
    wait_link(1);
    wait_link(1);
    for (int l = 0; l < 12; l++)
      chk("rx frame", p_frame ^ {128{l[0]}}, rx_frame[l]);
    $display("done rx");
  endtask

  task automatic t_peer();
    int c;
    chk("peer idle", 128'h0, 128'(peer));
    @(negedge sys_clk);
    p_run = 1'b1;
    for (c = 0; c < 700 && peer !== 1'b1; c++) @(negedge sys_clk);
    guard(c, 700);
    chk("peer seen", 128'h1, 128'(peer));
    t_rx(2'b00, 1'b1);
    p_run = 1'b0;
    for (c = 0; c < 900 && peer === 1'b1; c++) @(negedge sys_clk);
    guard(c, 900);
    chk("peer drop", 128'h1, 128'(c >= 190 && c <= 510));
    $display("done peer");
  endtask

  // Reset must also span three link edges, hence thirty system cycles
  initial begin
    repeat (30) @(negedge sys_clk);
    chk("rst sync", 128'h0, 128'({dn_sync, peer}));
    rst = 1'b0;
    t_sync();
    t_dir();
    t_tx();
    t_mirror();
    t_rx(2'b00, 1'b0);
    t_rx(2'b11, 1'b1);
    t_peer();
    wrap_up();
  end
endmodule
`default_nettype wire
